// [src/mode_detect_pkg.sv]
// Constants, register layout and types shared by the PCM/DSD mode detector.
// Contract
// - Detection runs only with auto mode on, powerdown pin high, register control mode.
// - With auto mode on, the manual format select is ignored; detected mode rules.
// - Auto mode adds 18 sample periods of PCM group delay.
// - Full-scale mute adds 136 or 264 DSD clocks of delay, per detect time.
// - Detected flag reads 0 for PCM, 1 for DSD; always 0 with auto off.
// - Detection starts on zero wait, attenuation zero, full-scale, power off, reset.
// - Zero wait select gives 8192, 4096, 2048 or 1024 plus 18 samples.
// - Three 8-bit zero codes seen twice in a row select DSD mode.
// - Frame pin toggling at N*16 bit clocks or constant 32 selects PCM.
// - Detection runs without master clock; outputs off until it returns.
// - Detection needs the bit clock; if it stops the mode is kept.
// - Each mode change asserts internal reset for three to four sample periods.
// - Each detection monitors 34 bit clocks, flag updates on frame rising edge or, for constant level, at once.
// - Non-zero data stops detection; restart needs the full zero wait again.
// - Soft reset release still 0 at enable starts detection at once.
// - After power-up the mode is PCM until DSD patterns are seen.
// - Stopped DSD data keeps DSD mode; input is treated as full-scale.
package mode_detect_pkg;

  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'h004;
  localparam logic [ADDR_W-1:0] DELAY_OFFSET = 12'h008;

  localparam int CTRL_W = 12;
  localparam int CTRL_AUTO_BIT = 0;
  localparam int CTRL_MANUAL_BIT = 1;
  localparam int CTRL_POWER_LSB = 2;
  localparam int CTRL_POWER_W = 4;
  localparam int CTRL_RESET_REL_BIT = 6;
  localparam int CTRL_FS_MUTE_BIT = 7;
  localparam int CTRL_FS_TIME_BIT = 8;
  localparam int CTRL_WAIT_LSB = 9;
  localparam int CTRL_EDGE_INV_BIT = 11;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h000;

  localparam int STAT_FLAG_BIT = 0;
  localparam int STAT_MODE_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_IRST_BIT = 3;
  localparam int STAT_OUTEN_BIT = 4;
  localparam int DELAY_DSD_LSB = 16;

  localparam logic [7:0] ZERO_CODE_A = 8'h69;
  localparam logic [7:0] ZERO_CODE_B = 8'h55;
  localparam logic [7:0] ZERO_CODE_C = 8'h33;

  localparam int MONITOR_BICK = 34;
  localparam int TOGGLE_UNIT_BICK = 16;
  localparam int CONST_BICK = 32;
  localparam int SAMPLE_BICK = 64;
  localparam int WAIT_BASE_SAMPLES = 8192;
  localparam int WAIT_EXTRA_SAMPLES = 18;
  localparam int PCM_EXTRA_DELAY = 18;
  localparam int DSD_DELAY_SHORT = 136;
  localparam int DSD_DELAY_LONG = 264;
  localparam int RESET_SAMPLES = 4;
  localparam int FS_TIME_SHORT_BICK = 1024;
  localparam int FS_TIME_LONG_BICK = 2048;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_MONITOR,
    ST_ALIGN,
    ST_RESET
  } detect_state_type;

endpackage : mode_detect_pkg

// [src/pattern_if.sv]
// Carrier between the mode controller and the frame pin pattern monitor.
interface pattern_if;
  logic bit_rise;
  logic frame_bit;
  logic clear;
  logic dsd_hit;
  logic toggle_hit;
  logic const_hit;

  modport ctrl (output bit_rise, output frame_bit, output clear,
                input dsd_hit, input toggle_hit, input const_hit);
  modport mon (input bit_rise, input frame_bit, input clear,
               output dsd_hit, output toggle_hit, output const_hit);
endinterface : pattern_if

// [src/pattern_monitor.sv]
// Frame pin pattern monitor: DSD zero codes, PCM toggle period, constant level.
module pattern_monitor
  import mode_detect_pkg::*;
(
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  pattern_if.mon pif // Sample strobe in, pattern results out.
);

  logic [15:0] shift_q;
  logic [9:0] interval_q;
  logic [5:0] level_cnt_q;
  logic last_level_q;
  logic seen_rise_q;
  logic dsd_hit_q;
  logic toggle_hit_q;
  logic const_hit_q;
  logic code_match;

  assign code_match = (shift_q == {ZERO_CODE_A, ZERO_CODE_A}) ||
                      (shift_q == {ZERO_CODE_B, ZERO_CODE_B}) ||
                      (shift_q == {ZERO_CODE_C, ZERO_CODE_C});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_q <= 16'h0000;
      dsd_hit_q <= 1'b0;
    end else if (pif.clear) begin
      shift_q <= 16'h0000;
      dsd_hit_q <= 1'b0;
    end else begin
      if (pif.bit_rise) begin
        shift_q <= {shift_q[14:0], pif.frame_bit};
      end
      if (code_match) begin
        dsd_hit_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interval_q <= 10'h000;
      level_cnt_q <= 6'h00;
      last_level_q <= 1'b0;
      seen_rise_q <= 1'b0;
      toggle_hit_q <= 1'b0;
      const_hit_q <= 1'b0;
    end else if (pif.clear) begin
      interval_q <= 10'h000;
      level_cnt_q <= 6'h00;
      last_level_q <= pif.frame_bit;
      seen_rise_q <= 1'b0;
      toggle_hit_q <= 1'b0;
      const_hit_q <= 1'b0;
    end else if (pif.bit_rise) begin
      last_level_q <= pif.frame_bit;
      if (pif.frame_bit != last_level_q) begin
        level_cnt_q <= 6'h00;
      end else if (level_cnt_q != 6'h3F) begin
        level_cnt_q <= level_cnt_q + 6'h01;
      end
      if (level_cnt_q >= 6'(CONST_BICK - 1) && pif.frame_bit == last_level_q) begin
        const_hit_q <= 1'b1;
      end
      if (pif.frame_bit && !last_level_q) begin
        if (seen_rise_q && interval_q != 10'h000 &&
            interval_q[3:0] == 4'(TOGGLE_UNIT_BICK % 16) &&
            interval_q != 10'h3FF) begin
          toggle_hit_q <= 1'b1;
        end
        interval_q <= 10'h001;
        seen_rise_q <= 1'b1;
      end else if (interval_q != 10'h3FF) begin
        interval_q <= interval_q + 10'h001;
      end
    end
  end

  assign pif.dsd_hit = dsd_hit_q;
  assign pif.toggle_hit = toggle_hit_q;
  assign pif.const_hit = const_hit_q;

endmodule : pattern_monitor

// [src/pcm_dsd_auto_mode_detect.sv]
// Automatic PCM/DSD format detector with its APB control and status registers.
module pcm_dsd_auto_mode_detect
  import mode_detect_pkg::*;
#(
  parameter int WAIT_BASE = mode_detect_pkg::WAIT_BASE_SAMPLES, // Zero wait at code 00.
  parameter int FS_SHORT = mode_detect_pkg::FS_TIME_SHORT_BICK, // Full-scale time, bit 0.
  parameter int FS_LONG = mode_detect_pkg::FS_TIME_LONG_BICK // Full-scale time, bit 1.
) (
  input wire logic pclk, // System clock, 250 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [mode_detect_pkg::ADDR_W-1:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error.
  input wire logic powerdown_pin, // Power-down pin, low powers down.
  input wire logic register_mode_pin, // High when in register control mode.
  input wire logic master_clock_present_pin, // High while the master clock runs.
  input wire logic bit_clock_pin, // Bit clock or DSD clock.
  input wire logic frame_or_dsd_data_pin, // Frame clock or DSD data.
  input wire logic serial_data_in_pin, // Serial audio data.
  input wire logic attenuation_zero, // All outputs zero through attenuation.
  output logic dsd_mode, // Format in use, high for DSD.
  output logic internal_reset_n, // Internal reset of the data path, active low.
  output logic output_enable, // Analog output driven; low means high impedance.
  output logic [7:0] pcm_extra_delay, // Added PCM group delay in samples.
  output logic [8:0] dsd_extra_delay // Added DSD delay in DSD clocks.
);

  localparam int NPIN = 6;
  localparam int P_BICK = 0;
  localparam int P_FRAME = 1;
  localparam int P_SERIAL_DATA_IN_PIN = 2;
  localparam int P_PDN = 3;
  localparam int P_REGM = 4;
  localparam int P_MCLK = 5;

  pattern_if pif ();

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_meta_q;
  logic [NPIN-1:0] pin_sync_q;
  logic bick_prev_q;
  logic frame_prev_q;
  logic bit_rise;
  logic frame_rise;
  logic [5:0] sample_cnt_q;
  logic sample_tick;
  logic [CTRL_W-1:0] ctrl_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic setup;
  logic access;
  logic auto_en;
  logic run;
  logic [13:0] zero_cnt_q;
  logic [13:0] wait_target;
  logic zero_met;
  logic [11:0] fs_cnt_q;
  logic [11:0] fs_target;
  logic fs_met;
  logic power_off;
  logic reset_held;
  logic start_cond;
  detect_state_type state_q;
  logic [5:0] mon_cnt_q;
  logic [2:0] rst_cnt_q;
  logic mode_q;
  logic result_q;
  logic fs_start_q;
  logic armed_q;
  logic clear_q;
  logic dsd_mode_q;
  logic irst_n_q;
  logic outen_q;
  logic [7:0] pcm_delay_q;
  logic [8:0] dsd_delay_q;
  logic [31:0] status_word;
  logic [31:0] delay_word;

  assign pin_raw = {master_clock_present_pin, register_mode_pin, powerdown_pin,
                    serial_data_in_pin, frame_or_dsd_data_pin, bit_clock_pin};

  // Every pin crosses into pclk through two flops.
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_meta_q[gi] <= 1'b0;
          pin_sync_q[gi] <= 1'b0;
        end else begin
          pin_meta_q[gi] <= pin_raw[gi];
          pin_sync_q[gi] <= pin_meta_q[gi];
        end
      end
    end
  endgenerate

  // Edges of the bit clock and the frame pin, found by pclk sampling.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bick_prev_q <= 1'b0;
      frame_prev_q <= 1'b0;
    end else begin
      bick_prev_q <= pin_sync_q[P_BICK];
      frame_prev_q <= pin_sync_q[P_FRAME];
    end
  end

  assign bit_rise = pin_sync_q[P_BICK] && !bick_prev_q;
  assign frame_rise = pin_sync_q[P_FRAME] && !frame_prev_q;

  // Sample period enable divided down from the bit clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_cnt_q <= 6'h00;
    end else if (bit_rise) begin
      sample_cnt_q <= (sample_cnt_q == 6'(SAMPLE_BICK - 1)) ? 6'h00 : sample_cnt_q + 6'h01;
    end
  end

  assign sample_tick = bit_rise && (sample_cnt_q == 6'(SAMPLE_BICK - 1));

  // APB slave with zero wait states; read data is captured in the setup cycle.
  assign setup = psel && !penable;
  assign access = psel && penable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (access && pwrite && paddr == CTRL_OFFSET) begin
      ctrl_q <= pwdata[CTRL_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      pready_q <= 1'b0;
    end else begin
      pready_q <= 1'b1;
      if (setup) begin
        if (paddr == CTRL_OFFSET) begin
          prdata_q <= {{(32 - CTRL_W){1'b0}}, ctrl_q};
          pslverr_q <= 1'b0;
        end else if (paddr == STATUS_OFFSET) begin
          prdata_q <= status_word;
          pslverr_q <= pwrite;
        end else if (paddr == DELAY_OFFSET) begin
          prdata_q <= delay_word;
          pslverr_q <= pwrite;
        end else begin
          prdata_q <= 32'h0000_0000;
          pslverr_q <= 1'b1;
        end
      end
    end
  end

  assign auto_en = ctrl_q[CTRL_AUTO_BIT];
  assign run = auto_en && pin_sync_q[P_PDN] && pin_sync_q[P_REGM];

  assign wait_target = 14'(WAIT_BASE >> ctrl_q[CTRL_WAIT_LSB +: 2]) + 14'(WAIT_EXTRA_SAMPLES);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_cnt_q <= 14'h0000;
    end else if (!run || pin_sync_q[P_SERIAL_DATA_IN_PIN]) begin
      zero_cnt_q <= 14'h0000;
    end else if (sample_tick && zero_cnt_q < wait_target) begin
      zero_cnt_q <= zero_cnt_q + 14'h0001;
    end
  end

  assign zero_met = zero_cnt_q >= wait_target;

  assign fs_target = ctrl_q[CTRL_FS_TIME_BIT] ? 12'(FS_LONG) : 12'(FS_SHORT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fs_cnt_q <= 12'h000;
    end else if (!run || !mode_q || !pin_sync_q[P_SERIAL_DATA_IN_PIN]) begin
      fs_cnt_q <= 12'h000;
    end else if (bit_rise && fs_cnt_q < fs_target) begin
      fs_cnt_q <= fs_cnt_q + 12'h001;
    end
  end

  assign fs_met = fs_cnt_q >= fs_target;
  assign power_off = ctrl_q[CTRL_POWER_LSB +: CTRL_POWER_W] == 4'h0;
  assign reset_held = !ctrl_q[CTRL_RESET_REL_BIT];
  assign start_cond = zero_met || attenuation_zero || fs_met || power_off || reset_held;

  // Detection sequencer; the mode itself lives here as well.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      mon_cnt_q <= 6'h00;
      rst_cnt_q <= 3'h0;
      mode_q <= 1'b0;
      result_q <= 1'b0;
      fs_start_q <= 1'b0;
      armed_q <= 1'b1;
      clear_q <= 1'b0;
    end else if (!pin_sync_q[P_PDN]) begin
      state_q <= ST_IDLE;
      mon_cnt_q <= 6'h00;
      rst_cnt_q <= 3'h0;
      mode_q <= 1'b0;
      result_q <= 1'b0;
      fs_start_q <= 1'b0;
      armed_q <= 1'b1;
      clear_q <= 1'b0;
    end else begin
      clear_q <= 1'b0;
      if (!start_cond) begin
        armed_q <= 1'b1;
      end
      case (state_q)
        ST_IDLE: begin
          if (run && armed_q && start_cond) begin
            state_q <= ST_MONITOR;
            mon_cnt_q <= 6'h00;
            clear_q <= 1'b1;
            fs_start_q <= fs_met && !zero_met && !attenuation_zero &&
                          !power_off && !reset_held;
          end
        end
        ST_MONITOR: begin
          if (!run || !start_cond) begin
            state_q <= ST_IDLE;
          end else if (bit_rise && !clear_q) begin
            if (mon_cnt_q == 6'(MONITOR_BICK - 1)) begin
              armed_q <= 1'b0;
              if (pif.dsd_hit) begin
                result_q <= 1'b1;
                state_q <= ST_ALIGN;
              end else if (pif.toggle_hit) begin
                result_q <= 1'b0;
                state_q <= ST_ALIGN;
              end else if (pif.const_hit && !fs_start_q) begin
                // No frame edge will come, so the result applies at once.
                mode_q <= 1'b0;
                if (mode_q) begin
                  state_q <= ST_RESET;
                  rst_cnt_q <= 3'h0;
                end else begin
                  state_q <= ST_IDLE;
                end
              end else begin
                state_q <= ST_IDLE;
              end
            end else begin
              mon_cnt_q <= mon_cnt_q + 6'h01;
            end
          end
        end
        ST_ALIGN: begin
          if (!run) begin
            state_q <= ST_IDLE;
          end else if (frame_rise) begin
            mode_q <= result_q;
            if (result_q != mode_q) begin
              state_q <= ST_RESET;
              rst_cnt_q <= 3'h0;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_RESET: begin
          if (sample_tick) begin
            if (rst_cnt_q == 3'(RESET_SAMPLES - 1)) begin
              state_q <= ST_IDLE;
            end else begin
              rst_cnt_q <= rst_cnt_q + 3'h1;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign pif.bit_rise = bit_rise;
  assign pif.frame_bit = pin_sync_q[P_FRAME];
  assign pif.clear = clear_q;

  pattern_monitor u_monitor (
    .pclk(pclk),
    .presetn(presetn),
    .pif(pif)
  );

  // Registered data path controls.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dsd_mode_q <= 1'b0;
      irst_n_q <= 1'b0;
      outen_q <= 1'b0;
      pcm_delay_q <= 8'h00;
      dsd_delay_q <= 9'h000;
    end else begin
      dsd_mode_q <= auto_en ? mode_q : ctrl_q[CTRL_MANUAL_BIT];
      irst_n_q <= pin_sync_q[P_PDN] && (state_q != ST_RESET);
      outen_q <= pin_sync_q[P_PDN] && pin_sync_q[P_MCLK] && (state_q != ST_RESET);
      pcm_delay_q <= auto_en ? 8'(PCM_EXTRA_DELAY) : 8'h00;
      if (!ctrl_q[CTRL_FS_MUTE_BIT]) begin
        dsd_delay_q <= 9'h000;
      end else if (ctrl_q[CTRL_FS_TIME_BIT]) begin
        dsd_delay_q <= 9'(DSD_DELAY_LONG);
      end else begin
        dsd_delay_q <= 9'(DSD_DELAY_SHORT);
      end
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[STAT_FLAG_BIT] = auto_en && mode_q;
    status_word[STAT_MODE_BIT] = dsd_mode_q;
    status_word[STAT_BUSY_BIT] = (state_q == ST_MONITOR) || (state_q == ST_ALIGN);
    status_word[STAT_IRST_BIT] = !irst_n_q;
    status_word[STAT_OUTEN_BIT] = outen_q;
  end

  assign delay_word = {7'h00, dsd_delay_q, 8'h00, pcm_delay_q};

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign dsd_mode = dsd_mode_q;
  assign internal_reset_n = irst_n_q;
  assign output_enable = outen_q;
  assign pcm_extra_delay = pcm_delay_q;
  assign dsd_extra_delay = dsd_delay_q;

endmodule : pcm_dsd_auto_mode_detect

// [bench/mode_detect_properties.sv]
// Port assertions for the PCM/DSD mode detector, and their bind.
module mode_detect_properties
  import mode_detect_pkg::*;
(
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset.
  input wire logic psel, // Select.
  input wire logic penable, // Enable.
  input wire logic pwrite, // Direction.
  input wire logic [mode_detect_pkg::ADDR_W-1:0] paddr, // Address.
  input wire logic [31:0] pwdata, // Write data.
  input wire logic [31:0] prdata, // Read data.
  input wire logic pready, // Ready.
  input wire logic powerdown_pin, // Power-down.
  input wire logic master_clock_present_pin, // Master clock.
  input wire logic bit_clock_pin, // Bit clock.
  input wire logic dsd_mode, // Mode.
  input wire logic internal_reset_n, // Data path reset.
  input wire logic output_enable, // Output drive.
  input wire logic [7:0] pcm_extra_delay, // PCM delay.
  input wire logic [8:0] dsd_extra_delay // DSD delay.
);
  logic [CTRL_W-1:0] ctrl_q;
  logic [2:0] bck_q;
  logic [9:0] irst_q;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Shadow of the control register, loaded by completed writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_q <= CTRL_RESET;
    else if (psel && penable && pready && pwrite && paddr == CTRL_OFFSET) ctrl_q <= pwdata[11:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) bck_q <= 3'h0;
    else bck_q <= {bck_q[1:0], bit_clock_pin};
  end

  // Counts bit clock rises while the data path is held in reset with the power-down pin high.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irst_q <= 10'h000;
    else if (internal_reset_n || !powerdown_pin) irst_q <= 10'h000;
    else if (bck_q[1] && !bck_q[2]) irst_q <= irst_q + 10'h001;
  end

  AST_PCM_DELAY: assert property (
    $stable(ctrl_q) && ctrl_q == $past(ctrl_q, 2) |->
    pcm_extra_delay == (ctrl_q[0] ? 8'h12 : 8'h00)) else $error("PCM delay wrong");
  AST_DSD_DELAY: assert property (
    $stable(ctrl_q) && ctrl_q == $past(ctrl_q, 2) |->
    dsd_extra_delay == (ctrl_q[7] ? (ctrl_q[8] ? 9'h108 : 9'h088) : 9'h000))
    else $error("DSD delay wrong");
  AST_MANUAL: assert property (
    !ctrl_q[0] && $stable(ctrl_q) && ctrl_q == $past(ctrl_q, 2) |-> dsd_mode == ctrl_q[1])
    else $error("manual mode not applied");
  AST_FLAG_OFF: assert property (
    psel && penable && !pwrite && paddr == STATUS_OFFSET && !ctrl_q[0] && !$past(ctrl_q[0], 2)
    |-> prdata[0] == 1'b0) else $error("flag set with auto off");
  AST_CHANGE_RESET: assert property (
    ctrl_q[0] && $past(ctrl_q[0], 3) && $changed(dsd_mode) |-> ##[0:3] !internal_reset_n)
    else $error("no reset on mode change");
  AST_RESET_LEN: assert property (
    $rose(internal_reset_n) |-> irst_q <= 10'h101) else $error("internal reset too long");
  AST_MCLK_OFF: assert property (
    !master_clock_present_pin [*6] |-> !output_enable) else $error("output without clock");
  AST_RESET_OFF: assert property (
    !internal_reset_n [*2] |-> !output_enable) else $error("output during reset");
  AST_PDN_PCM: assert property (
    !powerdown_pin [*6] ##0 (ctrl_q[0] && $past(ctrl_q[0])) |-> !dsd_mode)
    else $error("DSD in power-down");
endmodule : mode_detect_properties

bind pcm_dsd_auto_mode_detect mode_detect_properties u_mode_detect_properties (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .powerdown_pin, .master_clock_present_pin, .bit_clock_pin, .dsd_mode,
  .internal_reset_n, .output_enable, .pcm_extra_delay, .dsd_extra_delay
);

// [bench/audio_source_model.sv]
// Behavioural audio source: bit clock with frame clock or DSD zero code.
module audio_source_model (
  input wire logic run, // Bit clock runs while high.
  input wire logic [1:0] fmt, // 0 frame clock, 1 zero code, 2 steady low.
  input wire logic [7:0] code, // Zero code, MSB first.
  output logic bit_clock_pin, // Bit or DSD clock.
  output logic frame_or_dsd_data_pin // Frame clock or DSD data.
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] bit_cnt;

  initial begin
    bit_cnt = 4'h0;
    bit_clock_pin = 1'b0;
    frame_or_dsd_data_pin = 1'b0;
    forever begin
      #62.5;
      if (run) begin
        bit_clock_pin = ~bit_clock_pin;
        if (!bit_clock_pin) begin
          bit_cnt = bit_cnt + 4'h1;
          if (fmt == 2'h1) frame_or_dsd_data_pin = code[3'h7 - bit_cnt[2:0]];
          else frame_or_dsd_data_pin = (fmt == 2'h0) && bit_cnt[3];
        end
      end
    end
  end
endmodule : audio_source_model

// [bench/test_pcm_dsd_auto_mode_detect.sv]
// Self-checking bench for the PCM/DSD mode detector.
module test_pcm_dsd_auto_mode_detect
  import mode_detect_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, run;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic powerdown_pin, register_mode_pin, master_clock_present_pin, bit_clock_pin;
  logic frame_or_dsd_data_pin, serial_data_in_pin, attenuation_zero;
  logic dsd_mode, internal_reset_n, output_enable;
  logic [1:0] fmt;
  logic [7:0] code, pcm_extra_delay;
  logic [8:0] dsd_extra_delay;
  logic [7:0] codes [3] = '{8'h69, 8'h55, 8'h33};
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;

  pcm_dsd_auto_mode_detect #(.WAIT_BASE(16), .FS_SHORT(8), .FS_LONG(16))
  u_pcm_dsd_auto_mode_detect (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .powerdown_pin, .register_mode_pin, .master_clock_present_pin, .bit_clock_pin,
    .frame_or_dsd_data_pin, .serial_data_in_pin, .attenuation_zero, .dsd_mode,
    .internal_reset_n, .output_enable, .pcm_extra_delay, .dsd_extra_delay
  );

  audio_source_model u_audio_source_model (
    .run, .fmt, .code, .bit_clock_pin, .frame_or_dsd_data_pin
  );

  task automatic conclude();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Waits for the mode, then measures the data path reset that follows.
  task automatic await_mode(input logic m);
    int n;
    n = 0;
    while (dsd_mode !== m) @(posedge pclk);
    attenuation_zero <= 1'b0;
    serial_data_in_pin <= ~m;
    repeat (8200) begin
      @(posedge pclk);
      n += int'(internal_reset_n === 1'b0);
    end
    check({31'h0, n >= 5900 && n <= 8100}, 32'h1);
    check({31'h0, output_enable}, 32'h1);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    check(rdata & 32'h3, {30'h0, m, m});
  endtask : await_mode

  task automatic trigger(input logic [1:0] f, input logic m);
    fmt <= f;
    repeat (100) @(posedge pclk);
    attenuation_zero <= 1'b1;
    await_mode(m);
  endtask : trigger

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 90000) begin
      error_cnt++;
      conclude();
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, powerdown_pin, serial_data_in_pin} = 6'h00;
    {paddr, pwdata} = 44'h0;
    {register_mode_pin, master_clock_present_pin, attenuation_zero, run} = 4'hD;
    fmt = 2'h1;
    code = 8'h69;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, CTRL_OFFSET, 32'h0);
    check(rdata, 32'h0);
    apb(1'b0, DELAY_OFFSET, 32'h0);
    check(rdata, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    check({rdata[30:0], rerr}, 32'h1);
    apb(1'b1, STATUS_OFFSET, 32'h1);
    check({31'h0, rerr}, 32'h1);
    apb(1'b1, CTRL_OFFSET, 32'h2);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    check({29'h0, rdata[1:0], dsd_mode}, 32'h5);
    // written with soft reset release at 0
    apb(1'b1, CTRL_OFFSET, 32'h783);
    apb(1'b0, DELAY_OFFSET, 32'h0);
    check(rdata, 32'h0108_0012);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    check(rdata & 32'h7, 32'h0);
    apb(1'b1, CTRL_OFFSET, 32'h683);
    apb(1'b0, DELAY_OFFSET, 32'h0);
    check(rdata, 32'h0088_0012);
    register_mode_pin <= 1'b0;
    powerdown_pin <= 1'b1;
    repeat (2000) @(posedge pclk);
    check({31'h0, dsd_mode}, 32'h0);
    register_mode_pin <= 1'b1;
    await_mode(1'b1);
    // first two writes made while release is still 0
    apb(1'b1, CTRL_OFFSET, 32'h680);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    check(rdata & 32'h3, 32'h0);
    apb(1'b1, CTRL_OFFSET, 32'h6BF);
    apb(1'b1, CTRL_OFFSET, 32'h6FF);
    for (int i = 1; i < 4; i++) begin
      trigger((i == 2) ? 2'h2 : 2'h0, 1'b0);
      code <= codes[i % 3];
      trigger(2'h1, 1'b1);
    end
    run <= 1'b0;
    fmt <= 2'h0;
    attenuation_zero <= 1'b1;
    repeat (3000) @(posedge pclk);
    check({31'h0, dsd_mode}, 32'h1);
    master_clock_present_pin <= 1'b0;
    repeat (8) @(posedge pclk);
    check({31'h0, output_enable}, 32'h0);
    powerdown_pin <= 1'b0;
    repeat (8) @(posedge pclk);
    check({30'h0, dsd_mode, internal_reset_n}, 32'h0);
    conclude();
  end
endmodule : test_pcm_dsd_auto_mode_detect
